/* File: rtl/light_timing.sv */
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
// Integration timing core of the light sensor, reached over classic Wishbone.
module light_timing
  import lsi_pkg::*;
#(
  parameter int SCALE_RES_KOHM = 100  // Scaling resistor value in kOhm.
)
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Analog front end.
  input  wire logic        lightPulse,
  output logic             converting,
  output logic             arraySel,
  output logic             halfSpeed,
  output logic             resultReady
);

  // Cycles of sys_clk per full-speed oscillator cycle, rounded down.
  localparam int DIV_FULL = (CLK_KHZ * SCALE_RES_KOHM) / (REF_RES_KOHM * OSC_FULL_KHZ);

  generate
    if (DIV_FULL < 2)
    begin : g_chk
      $error("light_timing: scaling resistor too small for this clock");
    end
  endgenerate

  // ==========================================================================
  // Oscillator divider.
  osc_if oscBus ();

  osc_divider #(
    .DIV_FULL (DIV_FULL)
  ) uDiv (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .osc     (oscBus.src)
  );

  // ==========================================================================
  // State.
  logic [7:0]  cmd_q,    cmd_d;     // Command register.
  phase_e      phase_q,  phase_d;   // External sequence phase.
  logic [15:0] cyc_q,    cyc_d;     // Oscillator cycles this period.
  logic [15:0] pulse_q,  pulse_d;   // Front-end charge pulses this period.
  logic [15:0] data_q,   data_d;    // Published sensor result.
  logic [15:0] timer_q,  timer_d;   // Published cycle count.
  logic        done_q,   done_d;    // One-cycle result strobe.
  logic        ack_q,    ack_d;     // Bus acknowledge.
  logic [31:0] rdat_q,   rdat_d;    // Bus read data.

  // Decoded controls.
  logic        wbReq;
  logic        wrReq;
  logic [3:0]  idx;
  logic        cmdWr;
  logic        syncHit;
  logic        modeExt;
  logic [1:0]  resCode;
  logic [4:0]  expM;
  logic [15:0] lastCyc;
  logic [15:0] widthMask;
  logic [15:0] cycNext;
  logic [15:0] pulseNext;
  logic [15:0] pubData;
  logic        intEnd;

  // ==========================================================================
  // Decode of command fields and bus strobes.
  always_comb
  begin
    wbReq     = wb_cyc_i && wb_stb_i && !ack_q;
    wrReq     = wbReq && wb_we_i && wb_sel_i[0];
    idx       = wb_adr_i[5:2];
    modeExt   = cmd_q[CMD_MODE_BIT];
    resCode   = cmd_q[CMD_RES_LSB +: 2];
    expM      = 5'(EXP_BASE + EXP_STEP * int'(resCode));
    // The last cycle index of an internal period is 2^m - 1.
    lastCyc   = 16'((32'h1 << expM) - 32'h1);
    // The result holds n = m - 1 bits.
    widthMask = 16'((32'h1 << (expM - 5'h01)) - 32'h1);
    cmdWr     = wrReq && (idx == IDX_CMD);
    // Sync commands only mean something in external timing.
    syncHit   = wrReq && (idx == IDX_SYNC) && modeExt;
    // Both counters stick at full scale so an overflow stays visible.
    cycNext   = (oscBus.tick && cyc_q != CNT_MAX) ? cyc_q + 16'h0001 : cyc_q;
    pulseNext = (lightPulse && pulse_q != CNT_MAX) ? pulse_q + 16'h0001 : pulse_q;
    pubData   = (pulseNext > widthMask) ? widthMask : pulseNext;
    intEnd    = !modeExt && oscBus.tick && (cyc_q == lastCyc);
  end

  // Ranges zero and one ask for the slow oscillator, in either mode.
  assign oscBus.halfSpeed = !cmd_q[CMD_RANGE_LSB + 1];
  assign halfSpeed        = oscBus.halfSpeed;
  assign converting       = modeExt ? (phase_q != PH_IDLE) : 1'b1;
  assign arraySel         = (phase_q == PH_ARR2);
  assign resultReady      = done_q;
  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = rdat_q;

  // ==========================================================================
  // Next state of the integration sequencer.
  always_comb
  begin
    cmd_d   = cmd_q;
    phase_d = phase_q;
    cyc_d   = cyc_q;
    pulse_d = pulse_q;
    data_d  = data_q;
    timer_d = timer_q;
    done_d  = 1'b0;
    if (cmdWr)
    begin
      // A new command restarts integration from a clean count.
      cmd_d   = wb_dat_i[7:0];
      phase_d = PH_IDLE;
      cyc_d   = 16'h0000;
      pulse_d = 16'h0000;
    end
    else if (modeExt)
    begin
      // External timing: the host's sync commands bound the period.
      if (phase_q != PH_IDLE)
      begin
        cyc_d   = cycNext;
        pulse_d = pulseNext;
      end
      if (syncHit)
      begin
        unique case (phase_q)
          PH_IDLE:
          begin
            phase_d = PH_ARR1;
            cyc_d   = 16'h0000;
            pulse_d = 16'h0000;
          end
          PH_ARR1:
          begin
            phase_d = PH_ARR2;
          end
          PH_ARR2:
          begin
            // End array two, publish and start array one at once.
            data_d  = pubData;
            timer_d = cycNext;
            done_d  = 1'b1;
            phase_d = PH_ARR1;
            cyc_d   = 16'h0000;
            pulse_d = 16'h0000;
          end
          default:
          begin
            phase_d = PH_IDLE;
          end
        endcase
      end
    end
    else
    begin
      // Internal timing: a fixed count of oscillator cycles.
      phase_d = PH_IDLE;
      cyc_d   = cycNext;
      pulse_d = pulseNext;
      if (intEnd)
      begin
        data_d  = pubData;
        timer_d = cycNext;
        done_d  = 1'b1;
        cyc_d   = 16'h0000;
        pulse_d = 16'h0000;
      end
    end
  end

  // Register the sequencer.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cmd_q   <= CMD_RESET;
      phase_q <= PH_IDLE;
      cyc_q   <= 16'h0000;
      pulse_q <= 16'h0000;
      data_q  <= 16'h0000;
      timer_q <= 16'h0000;
      done_q  <= 1'b0;
    end
    else
    begin
      cmd_q   <= cmd_d;
      phase_q <= phase_d;
      cyc_q   <= cyc_d;
      pulse_q <= pulse_d;
      data_q  <= data_d;
      timer_q <= timer_d;
      done_q  <= done_d;
    end
  end

  // ==========================================================================
  // Bus answer: one cycle after the request, unmapped reads return zero.
  always_comb
  begin
    ack_d  = wbReq;
    rdat_d = 32'h00000000;
    unique case (idx)
      IDX_CMD:     rdat_d[7:0] = cmd_q;
      IDX_DATA_LO: rdat_d[7:0] = data_q[7:0];
      IDX_DATA_HI: rdat_d[7:0] = data_q[15:8];
      IDX_TMR_LO:  rdat_d[7:0] = timer_q[7:0];
      IDX_TMR_HI:  rdat_d[7:0] = timer_q[15:8];
      IDX_STATUS:
      begin
        rdat_d[1:0]                = phase_q;
        rdat_d[STAT_ADDR_LSB +: 7] = TARGET_ADDR;
      end
      default:     rdat_d = 32'h00000000;
    endcase
  end

  // Register the bus answer; read data is only loaded with a request.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= ack_d;
      if (wbReq)
        rdat_q <= rdat_d;
    end
  end

  // ==========================================================================
  // Checks.
  logic [15:0] expInt;
  always_comb
  begin
    expInt = (resCode == 2'b11) ? CNT_MAX : 16'(32'h1 << expM);
  end

  a_int_period: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (done_q && !modeExt && !$past(cmdWr)) |-> (timer_q == expInt))
    else $error("internal period length wrong");

  a_mode_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !modeExt |=> (phase_q == PH_IDLE) || $past(cmdWr))
    else $error("external phase used in internal mode");

  a_sync_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (syncHit && phase_q == PH_IDLE) |=> (converting && !arraySel && cyc_q == 16'h0000))
    else $error("first sync did not start array one");

  a_sync_second: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (syncHit && phase_q == PH_ARR1) |=> (arraySel && !done_q))
    else $error("second sync did not move to array two");

  // The publish strobe must stand for exactly one cycle while array one restarts.
  a_sync_third: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (syncHit && phase_q == PH_ARR2) |=>
      (resultReady && phase_q == PH_ARR1 && !arraySel && cyc_q == 16'h0000) ##1 !resultReady)
    else $error("third sync did not publish and restart");

  a_ext_no_fixed: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (done_q && modeExt) |-> $past(syncHit))
    else $error("external result without sync");

  a_counter_sat: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (modeExt && cyc_q == CNT_MAX && !syncHit && !cmdWr) |=> (cyc_q == CNT_MAX))
    else $error("cycle counter wrapped");

  a_data_width: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (done_d && !cmdWr) |=> (data_q <= widthMask))
    else $error("result exceeds selected width");

  a_half_speed: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1 |-> (halfSpeed == (cmd_q[CMD_RANGE_LSB +: 2] < 2'd2)))
    else $error("oscillator speed does not follow range");

  a_ack_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q ##1 !ack_q)
    else $error("bus acknowledge not a single cycle");

  c_int_result: cover property (@(posedge sys_clk) disable iff (sys_rst) done_q && !modeExt);
  c_ext_result: cover property (@(posedge sys_clk) disable iff (sys_rst) done_q && modeExt);
  c_sat_reached: cover property (@(posedge sys_clk) disable iff (sys_rst) modeExt && cyc_q == CNT_MAX);
  c_second_sync: cover property (@(posedge sys_clk) disable iff (sys_rst) syncHit && phase_q == PH_ARR1);

endmodule

/* File: rtl/lsi_pkg.sv */
// Summary of operation
// - Command bit five selects internal or external timing.
// - Internal period lasts two-power-m oscillator cycles.
// - Command bits one and zero select resolution.
// - Ranges zero, one run oscillator at half speed.
// - Oscillator behaves identically in both timing modes.
// - First sync starts array one, second starts two.
// - Third sync ends array two, publishes, restarts.
// - External mode counts oscillator cycles into timer.
// - External mode forces no power-of-two count.
// - Target answers at fixed address 1000100.
// - Timer low byte six, high byte seven.
// - Sensor result at four and five, refreshed.
// - Result width is 3, 7, 11 or 15.
package lsi_pkg;

  // ==========================================================================
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [3:0] IDX_CMD     = 4'h0;
  localparam logic [3:0] IDX_DATA_LO = 4'h4;
  localparam logic [3:0] IDX_DATA_HI = 4'h5;
  localparam logic [3:0] IDX_TMR_LO  = 4'h6;
  localparam logic [3:0] IDX_TMR_HI  = 4'h7;
  localparam logic [3:0] IDX_SYNC    = 4'h8;
  localparam logic [3:0] IDX_STATUS  = 4'h9;

  // ==========================================================================
  // Command register fields and reset value.
  localparam int         CMD_RES_LSB   = 0;
  localparam int         CMD_RANGE_LSB = 2;
  localparam int         CMD_MODE_BIT  = 5;
  localparam logic [7:0] CMD_RESET     = 8'h00;

  // Status register fields.
  localparam int         STAT_ADDR_LSB = 8;
  localparam logic [6:0] TARGET_ADDR   = 7'h44;

  // ==========================================================================
  // Integration exponent m = base + step * resolution code.
  localparam int          EXP_BASE = 4;
  localparam int          EXP_STEP = 4;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;

  // ==========================================================================
  // Oscillator timing: full speed in kHz at the reference resistor.
  localparam int OSC_FULL_KHZ  = 655;
  localparam int CLK_KHZ       = 100000;
  localparam int REF_RES_KOHM  = 100;

  // Integration phases of the external timing sequence.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ARR1 = 2'b01,
    PH_ARR2 = 2'b10
  } phase_e;

endpackage

/* File: rtl/osc_divider.sv */
`timescale 1ns/100ps
// Dual-speed oscillator model: a divider emitting one tick per oscillator cycle.
module osc_divider
  import lsi_pkg::*;
#(
  parameter int DIV_FULL = 152
)
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Tick out, speed in.
  osc_if.src        osc
);

  generate
    if (DIV_FULL < 2)
    begin : g_chk
      $error("osc_divider: DIV_FULL must be at least 2");
    end
  endgenerate

  // ==========================================================================
  // Divider state.
  logic [17:0] cnt_q;   // Cycles into the current oscillator period.
  logic [17:0] cnt_d;
  logic [17:0] limit;   // Last count of a period at the current speed.

  // The slow rate doubles the period, so both modes see the same clock.
  always_comb
  begin
    limit = osc.halfSpeed ? 18'(2 * DIV_FULL - 1) : 18'(DIV_FULL - 1);
    osc.tick = (cnt_q >= limit);
    cnt_d = osc.tick ? 18'h00000 : cnt_q + 18'h00001;
  end

  // Register the divider count.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cnt_q <= 18'h00000;
    else
      cnt_q <= cnt_d;
  end

  // ==========================================================================
  // Helper: ticks are spaced by the full period while the speed is unchanged.
  logic [17:0] span_q;
  logic        spanOk_q;
  logic        spdPrev_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      span_q    <= 18'h00000;
      spanOk_q  <= 1'b0;
      spdPrev_q <= 1'b0;
    end
    else
    begin
      spdPrev_q <= osc.halfSpeed;
      span_q    <= osc.tick ? 18'h00000 : span_q + 18'h00001;
      if (osc.halfSpeed != spdPrev_q)
        spanOk_q <= 1'b0;
      else if (osc.tick)
        spanOk_q <= 1'b1;
    end
  end

  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (osc.tick && spanOk_q && osc.halfSpeed == spdPrev_q) |-> (span_q == limit))
    else $error("oscillator tick spacing wrong");

endmodule

/* File: rtl/osc_if.sv */
`timescale 1ns/100ps
// Oscillator tick and speed request between the timing core and the divider.
interface osc_if;
  logic tick;       // One-cycle enable per oscillator cycle.
  logic halfSpeed;  // High selects the slow oscillator rate.
  modport src (output tick, input halfSpeed);
  modport snk (input tick, output halfSpeed);
endinterface

/* File: sim/light_source.sv */
`timescale 1ns/100ps
// ============================================================================
// Front-end stand-in: one charge-balance pulse every other cycle while the
// core converts and light is on, so the result clamps at every resolution.
module light_source
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Light switch from the bench, gate from the core.
  input  wire logic lightOn,
  input  wire logic converting,
  // Pulse to the core.
  output logic      lightPulse
);
  logic toggle_q;  // Alternates so pulses are never back to back.
  logic toggle_d;  // Next value of the alternation flop.

  // Next state: flip only while pulses are wanted.
  always_comb
  begin
    toggle_d = (lightOn && converting) ? !toggle_q : 1'b0;
  end

  // Register the alternation.
  always_ff @(posedge sys_clk)
  begin
    toggle_q <= sys_rst ? 1'b0 : toggle_d;
  end

  assign lightPulse = toggle_q;
endmodule

/* File: sim/light_timing_tb.sv */
`timescale 1ns/100ps
// ============================================================================
// Self-checking bench for the integration timing core.
module light_timing_tb
  import lsi_pkg::*;
;
  localparam int DIV = 3;  // Sys clocks per full-speed tick with the resistor set to 2.
  logic        sys_clk = 1'b0;  // Only the clock process below writes it.
  logic        sys_rst, wbCyc, wbStb, wbWe, lightOn, lightPulse;
  logic        converting, arraySel, halfSpeed, resultReady, wbAck, rdyAtAck;
  logic [5:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, q;
  int          errors, check_count, cyc, ackCyc;

  // ==========================================================================
  // Design and front-end model.
  light_timing #(.SCALE_RES_KOHM(2)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .lightPulse(lightPulse), .converting(converting),
    .arraySel(arraySel), .halfSpeed(halfSpeed), .resultReady(resultReady));
  light_source src_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .lightOn(lightOn),
    .converting(converting), .lightPulse(lightPulse));

  // Clock and a cycle counter used to time sync intervals.
  always #5 sys_clk = !sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ==========================================================================
  // Helpers.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb_io(input logic we, input logic [3:0] idx, input logic [7:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= {idx, 2'b00};
    wbSel  <= sel;
    wbDatI <= {24'h000000, d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    q        = wbDatO;
    rdyAtAck = resultReady;
    ackCyc   = cyc;
    wbCyc   <= 1'b0;
    wbStb   <= 1'b0;
    wbWe    <= 1'b0;
    check(n < 20, 1'b1);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    wb_io(1'b1, idx, d, 4'hF);
  endtask

  task automatic rd(input logic [3:0] idx);
    wb_io(1'b0, idx, 8'h00, 4'hF);
  endtask

  // Count edges until the next publish pulse; bounded.
  task automatic wait_ready(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (resultReady !== 1'b1 && n < 60000);
  endtask

  // ==========================================================================
  // Scenarios.
  // Reset values, ignored writes and an unmapped place.
  task automatic reset_case();
    check(halfSpeed, 1'b1);
    check({converting, arraySel}, 2'b10);
    rd(IDX_CMD);
    check(q, CMD_RESET);
    wr(IDX_SYNC, 8'h01);
    rd(IDX_STATUS);
    check(q, {17'h0, TARGET_ADDR, 8'h00});
    wb_io(1'b1, IDX_CMD, 8'h20, 4'hE);
    wr(4'hA, 8'h55);
    rd(IDX_CMD);
    check(q, CMD_RESET);
    rd(4'hA);
    check(q, 32'h0);
  endtask

  // Internal timing: period length, timer and clamped data.
  task automatic int_case(input logic [1:0] res, input logic [1:0] rng, input logic lit);
    int          gap;
    int          m;
    logic [15:0] tm;
    logic [15:0] dt;
    m        = 4 + 4 * res;
    tm       = 16'(1 << m);
    dt       = lit ? 16'((1 << (m - 1)) - 1) : 16'h0000;
    lightOn <= lit;
    wr(IDX_CMD, {2'b00, 1'b0, 1'b0, rng, res});
    check(halfSpeed, rng < 2);
    wait_ready(gap);
    wait_ready(gap);
    check(gap, (rng < 2 ? 2 : 1) * DIV * (1 << m));
    rd(IDX_TMR_LO);
    check(q, tm[7:0]);
    rd(IDX_TMR_HI);
    check(q, tm[15:8]);
    rd(IDX_DATA_LO);
    check(q, dt[7:0]);
    rd(IDX_DATA_HI);
    check(q, dt[15:8]);
  endtask

  // External timing: three syncs, phases, publish and timer.
  task automatic ext_case();
    int          c0;
    logic [15:0] tm;
    lightOn <= 1'b1;
    wr(IDX_CMD, 8'h2D);
    check(halfSpeed, 1'b0);
    wr(IDX_SYNC, 8'h01);
    c0 = ackCyc;
    rd(IDX_STATUS);
    check({q[1:0], arraySel, converting}, 4'b0101);
    repeat (300) @(posedge sys_clk);
    wr(IDX_SYNC, 8'h01);
    rd(IDX_STATUS);
    check({q[1:0], arraySel, converting}, 4'b1011);
    repeat (300) @(posedge sys_clk);
    wr(IDX_SYNC, 8'h01);
    check(rdyAtAck, 1'b1);
    c0 = (ackCyc - c0) / DIV;
    rd(IDX_STATUS);
    check({q[1:0], arraySel}, 3'b010);
    rd(IDX_TMR_LO);
    tm[7:0] = q[7:0];
    rd(IDX_TMR_HI);
    tm[15:8] = q[7:0];
    check(tm >= c0 - 1 && tm <= c0 + 1, 1'b1);
    rd(IDX_DATA_LO);
    check(q, 32'h7F);
  endtask

  // ==========================================================================
  // Verdict, watchdog and main sequence.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The planned run is about 30k cycles; nearly twice that means a hang.
  initial
  begin
    #600000;
    errors++;
    print_verdict();
  end

  initial
  begin
    {wbCyc, wbStb, wbWe, lightOn} = 4'b0001;
    {wbAdr, wbSel, wbDatI} = '0;
    sys_rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    reset_case();
    int_case(2'd0, 2'd0, 1'b1);
    int_case(2'd0, 2'd2, 1'b0);
    int_case(2'd1, 2'd1, 1'b1);
    int_case(2'd1, 2'd3, 1'b1);
    int_case(2'd2, 2'd2, 1'b1);
    ext_case();
    print_verdict();
  end
endmodule
